// file: design/crr_result_regs.sv
// The APB slave port was chosen for this implementation.
module crr_result_regs (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [crr_pkg::APB_ADDR_W-1:0] paddr,
    input  wire logic [crr_pkg::APB_DATA_W-1:0] pwdata,
    output wire logic [crr_pkg::APB_DATA_W-1:0] prdata,
    output wire logic                           pready,
    output wire logic                           pslverr,
    input  wire logic                           meas_done,
    input  wire logic [crr_pkg::SEL_W-1:0]      meas_sel,
    input  wire logic [crr_pkg::WORD_W-1:0]     meas_word
);

    ////////////////////////////////////////////////////////////////////////////////
    // State of the block.
    typedef struct packed {
        crr_pkg::crr_apb_state_type     state;
        logic                           pready;
        logic                           pslverr;
        logic [crr_pkg::APB_DATA_W-1:0] prdata;
        crr_pkg::crr_result_type        result;
    } crr_state_type;

    crr_state_type state;
    crr_state_type next_state;
    crr_if         link ();

    ////////////////////////////////////////////////////////////////////////////////
    // Assembles the read word of one register from its fields.
    function automatic logic [crr_pkg::WORD_W-1:0] crr_pack_word(
        input crr_pkg::crr_result_type r,
        input logic [crr_pkg::SEL_W-1:0] sel
    );
        logic [crr_pkg::WORD_W-1:0] w;
        w = crr_pkg::RSVD_FILL;
        unique case (sel)
            crr_pkg::SEL_PAIR_B_ECHO_POS_2_3: begin
                w[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W] = r.pair_b_second_echo_pos;
                w[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W] = r.pair_b_third_echo_pos;
            end
            crr_pkg::SEL_PAIR_B_ECHO_POS_4_5: begin
                w[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W] = r.pair_b_fourth_echo_pos;
                w[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W] = r.pair_b_fifth_echo_pos;
            end
            crr_pkg::SEL_PAIR_C_ECHO_POS_1_2: begin
                w[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W] = r.pair_c_first_echo_pos;
                w[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W] = r.pair_c_second_echo_pos;
            end
            crr_pkg::SEL_PAIR_C_ECHO_POS_3_4: begin
                w[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W] = r.pair_c_third_echo_pos;
                w[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W] = r.pair_c_fourth_echo_pos;
            end
            crr_pkg::SEL_PAIR_C5_D1_ECHO_POS: begin
                w[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W] = r.pair_c_fifth_echo_pos;
                w[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W] = r.pair_d_first_echo_pos;
            end
            crr_pkg::SEL_PAIR_D_ECHO_POS_2_3: begin
                w[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W] = r.pair_d_second_echo_pos;
                w[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W] = r.pair_d_third_echo_pos;
            end
            crr_pkg::SEL_PAIR_D_ECHO_POS_4_5: begin
                w[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W] = r.pair_d_fourth_echo_pos;
                w[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W] = r.pair_d_fifth_echo_pos;
            end
            crr_pkg::SEL_PAIR_A_ECHO_AMP_1_2: begin
                w[crr_pkg::AMP_LO_LSB+:crr_pkg::AMP_W] = r.pair_a_first_echo_amp;
                w[crr_pkg::AMP_HI_LSB+:crr_pkg::AMP_W] = r.pair_a_second_echo_amp;
            end
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and measurement loading.
    assign link.paddr    = paddr;
    assign link.cur      = state.result;
    assign link.upd_done = meas_done;
    assign link.upd_sel  = meas_sel;
    assign link.upd_word = meas_word;

    crr_addr_decode u_decode (
        .bus (link.decoder)
    );

    crr_word_update u_update (
        .bus (link.updater)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: APB slave answering with one access cycle.
    always_comb begin
        next_state        = state;
        next_state.result = link.next_result;
        if (state.state == crr_pkg::CRR_IDLE) begin
            next_state.pready  = 1'b0;
            next_state.pslverr = 1'b0;
            next_state.prdata  = crr_pkg::RESET_RDATA;
            if (psel && !penable) begin
                next_state.state   = crr_pkg::CRR_ACCESS;
                next_state.pready  = 1'b1;
                next_state.pslverr = !link.dec.hit;
                if (!pwrite && link.dec.hit) begin
                    next_state.prdata = {crr_pkg::ZERO_WORD,
                                         crr_pack_word(state.result, link.dec.sel)};
                end
            end
        end else begin
            next_state.state   = crr_pkg::CRR_IDLE;
            next_state.pready  = 1'b0;
            next_state.pslverr = 1'b0;
            next_state.prdata  = crr_pkg::RESET_RDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.state   <= crr_pkg::CRR_IDLE;
            state.pready  <= 1'b0;
            state.pslverr <= 1'b0;
            state.prdata  <= crr_pkg::RESET_RDATA;
            state.result  <= '{default: '0};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign prdata  = state.prdata;
    assign pready  = state.pready;
    assign pslverr = state.pslverr;

endmodule // crr_result_regs

// file: design/crr_pkg.sv
package crr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and field widths.
    localparam int APB_DATA_W = 32;
    localparam int APB_ADDR_W = 12;
    localparam int WORD_W     = 16;
    localparam int POS_W      = 8;
    localparam int AMP_W      = 7;
    localparam int SEL_W      = 3;
    localparam int IDX_W      = 9;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices as printed; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_PAIR_B_ECHO_POS_2_3 = 9'h193;
    localparam logic [IDX_W-1:0] IDX_PAIR_B_ECHO_POS_4_5 = 9'h194;
    localparam logic [IDX_W-1:0] IDX_PAIR_C_ECHO_POS_1_2 = 9'h195;
    localparam logic [IDX_W-1:0] IDX_PAIR_C_ECHO_POS_3_4 = 9'h196;
    localparam logic [IDX_W-1:0] IDX_PAIR_C5_D1_ECHO_POS = 9'h197;
    localparam logic [IDX_W-1:0] IDX_PAIR_D_ECHO_POS_2_3 = 9'h198;
    localparam logic [IDX_W-1:0] IDX_PAIR_D_ECHO_POS_4_5 = 9'h199;
    localparam logic [IDX_W-1:0] IDX_PAIR_A_ECHO_AMP_1_2 = 9'h19A;
    localparam logic [1:0]       ADDR_ALIGN_BITS         = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Register select codes shared by decode, update and read paths.
    localparam logic [SEL_W-1:0] SEL_PAIR_B_ECHO_POS_2_3 = 3'h0;
    localparam logic [SEL_W-1:0] SEL_PAIR_B_ECHO_POS_4_5 = 3'h1;
    localparam logic [SEL_W-1:0] SEL_PAIR_C_ECHO_POS_1_2 = 3'h2;
    localparam logic [SEL_W-1:0] SEL_PAIR_C_ECHO_POS_3_4 = 3'h3;
    localparam logic [SEL_W-1:0] SEL_PAIR_C5_D1_ECHO_POS = 3'h4;
    localparam logic [SEL_W-1:0] SEL_PAIR_D_ECHO_POS_2_3 = 3'h5;
    localparam logic [SEL_W-1:0] SEL_PAIR_D_ECHO_POS_4_5 = 3'h6;
    localparam logic [SEL_W-1:0] SEL_PAIR_A_ECHO_AMP_1_2 = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int POS_HI_LSB = 8;
    localparam int POS_LO_LSB = 0;
    localparam int AMP_HI_LSB = 8;
    localparam int AMP_LO_LSB = 0;

    localparam logic [POS_W-1:0]      RESET_POS   = 8'h00;
    localparam logic [AMP_W-1:0]      RESET_AMP   = 7'h00;
    localparam logic [APB_DATA_W-1:0] RESET_RDATA = 32'h00000000;
    localparam logic [WORD_W-1:0]     ZERO_WORD   = 16'h0000;
    localparam logic [WORD_W-1:0]     RSVD_FILL   = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef struct packed {
        logic [POS_W-1:0] pair_b_second_echo_pos;
        logic [POS_W-1:0] pair_b_third_echo_pos;
        logic [POS_W-1:0] pair_b_fourth_echo_pos;
        logic [POS_W-1:0] pair_b_fifth_echo_pos;
        logic [POS_W-1:0] pair_c_first_echo_pos;
        logic [POS_W-1:0] pair_c_second_echo_pos;
        logic [POS_W-1:0] pair_c_third_echo_pos;
        logic [POS_W-1:0] pair_c_fourth_echo_pos;
        logic [POS_W-1:0] pair_c_fifth_echo_pos;
        logic [POS_W-1:0] pair_d_first_echo_pos;
        logic [POS_W-1:0] pair_d_second_echo_pos;
        logic [POS_W-1:0] pair_d_third_echo_pos;
        logic [POS_W-1:0] pair_d_fourth_echo_pos;
        logic [POS_W-1:0] pair_d_fifth_echo_pos;
        logic [AMP_W-1:0] pair_a_first_echo_amp;
        logic [AMP_W-1:0] pair_a_second_echo_amp;
    } crr_result_type;

    typedef struct packed {
        logic             hit;
        logic [SEL_W-1:0] sel;
    } crr_decode_type;

    typedef enum logic {
        CRR_IDLE,
        CRR_ACCESS
    } crr_apb_state_type;

endpackage

// file: design/crr_if.sv
interface crr_if;
    logic [crr_pkg::APB_ADDR_W-1:0] paddr;
    crr_pkg::crr_decode_type        dec;
    crr_pkg::crr_result_type        cur;
    logic                           upd_done;
    logic [crr_pkg::SEL_W-1:0]      upd_sel;
    logic [crr_pkg::WORD_W-1:0]     upd_word;
    crr_pkg::crr_result_type        next_result;

    modport decoder (input paddr, output dec);
    modport updater (input cur, input upd_done, input upd_sel, input upd_word,
                     output next_result);
    modport top     (output paddr, output cur, output upd_done, output upd_sel,
                     output upd_word, input dec, input next_result);
endinterface

// file: design/crr_addr_decode.sv
module crr_addr_decode (
    crr_if.decoder bus
);

    ////////////////////////////////////////////////////////////////////////////////
    // Maps a byte address to a register select; anything else is a miss.
    function automatic crr_pkg::crr_decode_type crr_decode_addr(
        input logic [crr_pkg::APB_ADDR_W-1:0] addr
    );
        crr_pkg::crr_decode_type d;
        d.hit = 1'b0;
        d.sel = crr_pkg::SEL_PAIR_B_ECHO_POS_2_3;
        if (addr[1:0] == crr_pkg::ADDR_ALIGN_BITS) begin
            d.hit = 1'b1;
            case (addr[crr_pkg::APB_ADDR_W-1:2])
                (10'(crr_pkg::IDX_PAIR_B_ECHO_POS_2_3)): d.sel = crr_pkg::SEL_PAIR_B_ECHO_POS_2_3;
                (10'(crr_pkg::IDX_PAIR_B_ECHO_POS_4_5)): d.sel = crr_pkg::SEL_PAIR_B_ECHO_POS_4_5;
                (10'(crr_pkg::IDX_PAIR_C_ECHO_POS_1_2)): d.sel = crr_pkg::SEL_PAIR_C_ECHO_POS_1_2;
                (10'(crr_pkg::IDX_PAIR_C_ECHO_POS_3_4)): d.sel = crr_pkg::SEL_PAIR_C_ECHO_POS_3_4;
                (10'(crr_pkg::IDX_PAIR_C5_D1_ECHO_POS)): d.sel = crr_pkg::SEL_PAIR_C5_D1_ECHO_POS;
                (10'(crr_pkg::IDX_PAIR_D_ECHO_POS_2_3)): d.sel = crr_pkg::SEL_PAIR_D_ECHO_POS_2_3;
                (10'(crr_pkg::IDX_PAIR_D_ECHO_POS_4_5)): d.sel = crr_pkg::SEL_PAIR_D_ECHO_POS_4_5;
                (10'(crr_pkg::IDX_PAIR_A_ECHO_AMP_1_2)): d.sel = crr_pkg::SEL_PAIR_A_ECHO_AMP_1_2;
                default:                                  d.hit = 1'b0;
            endcase
        end
        return d;
    endfunction

    assign bus.dec = crr_decode_addr(bus.paddr);

endmodule // crr_addr_decode

// file: design/crr_word_update.sv
module crr_word_update (
    crr_if.updater bus
);

    ////////////////////////////////////////////////////////////////////////////////
    // Splits the finished measurement word into its low and high fields.
    logic [crr_pkg::POS_W-1:0] lo_pos;
    logic [crr_pkg::POS_W-1:0] hi_pos;
    logic [crr_pkg::AMP_W-1:0] lo_amp;
    logic [crr_pkg::AMP_W-1:0] hi_amp;

    assign lo_pos = bus.upd_word[crr_pkg::POS_LO_LSB+:crr_pkg::POS_W];
    assign hi_pos = bus.upd_word[crr_pkg::POS_HI_LSB+:crr_pkg::POS_W];
    assign lo_amp = bus.upd_word[crr_pkg::AMP_LO_LSB+:crr_pkg::AMP_W];
    assign hi_amp = bus.upd_word[crr_pkg::AMP_HI_LSB+:crr_pkg::AMP_W];

    ////////////////////////////////////////////////////////////////////////////////
    // Loads one finished measurement word into its fields; other fields hold.
    always_comb begin
        bus.next_result = bus.cur;
        if (bus.upd_done) begin
            unique case (bus.upd_sel)
                crr_pkg::SEL_PAIR_B_ECHO_POS_2_3: begin
                    bus.next_result.pair_b_second_echo_pos = lo_pos;
                    bus.next_result.pair_b_third_echo_pos  = hi_pos;
                end
                crr_pkg::SEL_PAIR_B_ECHO_POS_4_5: begin
                    bus.next_result.pair_b_fourth_echo_pos = lo_pos;
                    bus.next_result.pair_b_fifth_echo_pos  = hi_pos;
                end
                crr_pkg::SEL_PAIR_C_ECHO_POS_1_2: begin
                    bus.next_result.pair_c_first_echo_pos  = lo_pos;
                    bus.next_result.pair_c_second_echo_pos = hi_pos;
                end
                crr_pkg::SEL_PAIR_C_ECHO_POS_3_4: begin
                    bus.next_result.pair_c_third_echo_pos  = lo_pos;
                    bus.next_result.pair_c_fourth_echo_pos = hi_pos;
                end
                crr_pkg::SEL_PAIR_C5_D1_ECHO_POS: begin
                    bus.next_result.pair_c_fifth_echo_pos  = lo_pos;
                    bus.next_result.pair_d_first_echo_pos  = hi_pos;
                end
                crr_pkg::SEL_PAIR_D_ECHO_POS_2_3: begin
                    bus.next_result.pair_d_second_echo_pos = lo_pos;
                    bus.next_result.pair_d_third_echo_pos  = hi_pos;
                end
                crr_pkg::SEL_PAIR_D_ECHO_POS_4_5: begin
                    bus.next_result.pair_d_fourth_echo_pos = lo_pos;
                    bus.next_result.pair_d_fifth_echo_pos  = hi_pos;
                end
                crr_pkg::SEL_PAIR_A_ECHO_AMP_1_2: begin
                    bus.next_result.pair_a_first_echo_amp  = lo_amp;
                    bus.next_result.pair_a_second_echo_amp = hi_amp;
                end
            endcase
        end
    end

endmodule // crr_word_update

// file: verif/crr_result_regs_sva.sv
module crr_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        meas_done,
    input wire logic [2:0]  meas_sel,
    input wire logic [15:0] meas_word
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic unmapped;
    assign unmapped = (paddr[1:0] != 2'h0) || (paddr < 12'h64C) || (paddr > 12'h668);

    sequence s_setup;
        psel && !penable;
    endsequence

    property p_load_read;
        logic [2:0]  s;
        logic [15:0] w;
        (meas_done, s = meas_sel, w = meas_word) ##1
        (s_setup and (!pwrite && !meas_done && paddr == 12'h64C + {7'h00, s, 2'h0}))
        ##1 pready |-> prdata[15:0] == ((s == 3'h7) ? (w & 16'h7F7F) : w);
    endproperty

    a_ready_after_setup: assert property (s_setup |=> pready && penable)
        else $error("No answer in the cycle after setup.");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    a_unmapped_refused: assert property ((s_setup and unmapped) |=> pslverr && prdata == 32'h0)
        else $error("Unmapped access not refused.");
    a_mapped_accepted: assert property ((s_setup and !unmapped) |=> !pslverr)
        else $error("Mapped access refused.");
    a_write_no_data: assert property ((s_setup and pwrite) |=> prdata == 32'h0)
        else $error("Write returned data.");
    a_idle_bus_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("Bus outputs active outside the answer.");
    a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("Upper read data bits not zero.");
    a_amp_rsvd_zero: assert property ((s_setup and (paddr == 12'h668)) |=>
        !prdata[15] && !prdata[7])
        else $error("Reserved amplitude bits not zero.");
    a_load_read_back: assert property (p_load_read)
        else $error("Loaded word not read back in its place.");
endmodule // crr_checker

bind crr_result_regs crr_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_done(meas_done), .meas_sel(meas_sel),
    .meas_word(meas_word));

// file: verif/test_cable_reflection_result_regs.sv
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            err_total++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end

module test_cable_reflection_result_regs;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'hFFFFFFFF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        meas_done = 1'b0;
    logic [2:0]  meas_sel  = 3'h0;
    logic [15:0] meas_word = 16'h0000;
    int          err_total   = 0;
    int          check_count = 0;
    int          cycles      = 0;
    time         rel_t       = 0;

    crr_result_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_done(meas_done), .meas_sel(meas_sel), .meas_word(meas_word));

    always #50 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] reg_addr(input int i);
        return 12'h64C + 12'(i * 4);
    endfunction

    function automatic logic [15:0] word_of(input int i);
        return {4'h8, 4'(i), 4'hC, 4'(i)};
    endfunction

    function automatic logic [15:0] pattern(input int i);
        return (i == 7) ? (word_of(i) & 16'h7F7F) : word_of(i);
    endfunction

    task automatic xfer(input logic [11:0] a, input logic wr, input bit keep,
                        output logic [31:0] d, output logic e);
        if (rel_t == $time) @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
            rel_t = $time;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] x, input logic xe,
                      input bit keep, input string nm);
        logic [31:0] d;
        logic        e;
        xfer(a, 1'b0, keep, d, e);
        `CHK(nm, {16'h0000, x}, d)
        `CHK({nm, " error flag"}, xe, e)
    endtask

    task automatic load(input int i);
        meas_done <= 1'b1;
        meas_sel <= 3'(i);
        meas_word <= word_of(i);
        @(posedge pclk);
        meas_done <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        for (int i = 0; i < 8; i++) rd(reg_addr(i), 16'h0000, 1'b0, i < 7, "reset");
        $display("test reset values done");
    endtask

    task automatic t_layout();
        for (int i = 0; i < 8; i++) begin
            load(i);
            rd(reg_addr(i), pattern(i), 1'b0, 1'b0, "layout");
        end
        $display("test layout done");
    endtask

    task automatic t_write_ignored();
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 8; i++) begin
            xfer(reg_addr(i), 1'b1, 1'b1, d, e);
            `CHK("write error flag", 1'b0, e)
        end
        for (int i = 0; i < 8; i++) rd(reg_addr(i), pattern(i), 1'b0, i < 7, "kept");
        $display("test write ignored done");
    endtask

    task automatic t_unmapped();
        rd(12'h648, 16'h0000, 1'b1, 1'b1, "below map");
        rd(12'h66C, 16'h0000, 1'b1, 1'b1, "above map");
        rd(12'h64E, 16'h0000, 1'b1, 1'b0, "misaligned");
        $display("test unmapped done");
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        do_reset();
        t_reset_values();
        t_layout();
        t_write_ignored();
        t_unmapped();
        do_reset();
        t_reset_values();
        end_of_test();
    end
endmodule // test_cable_reflection_result_regs
